// File: core/uart_defs.svh
// Constants for the serial data buffer and first status register.
// Assumes inclusion from the package and the design files by bare name.
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// I/O locations (port addresses)
`define IO_ADDR_W           6
`define ADDR_DATA_PORT      6'h0C
`define ADDR_STATUS_A       6'h0B
`define ADDR_BAUD_HIGH      6'h20

// Status register field positions
`define BIT_RXC             7
`define BIT_TXC             6
`define BIT_BUFFER_EMPTY_FLAG            5
`define BIT_FE              4
`define BIT_DOR             3
`define BIT_PE              2
`define BIT_U2X             1
`define BIT_MULTIPROCESSOR_FILTER_BIT            0

// Reset values
`define STATUS_A_RESET      8'h20
`define TXD_IDLE            1'b1

// Oversampling per bit, normal and doubled speed
`define OS_NORMAL           5'h10
`define OS_DOUBLE           5'h08

// Receive buffer depth
`define RX_FIFO_DEPTH       2

`endif

// File: core/uart_pkg.sv
// Types shared by the serial data buffer and its receive FIFO.
// Assumes uart_defs.svh is on the include path.
`include "uart_defs.svh"

package uart_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_err;
    logic       parity_err;
  } rx_entry_type;

  // Character size: 0 = 5 bits .. 3 = 8 bits
  typedef struct packed {
    logic [1:0] char_size;
    logic       parity_en;
    logic       parity_odd;
    logic       two_stop;
  } frame_cfg_type;

  typedef struct packed {
    logic receive_complete_flag;
    logic transmit_complete_flag;
    logic buffer_empty_flag;
  } irq_type;

  typedef enum logic [2:0] {
    LINE_IDLE   = 3'b000,
    LINE_START  = 3'b001,
    LINE_DATA   = 3'b011,
    LINE_PARITY = 3'b010,
    LINE_STOP   = 3'b110
  } line_state_type;

endpackage

// File: core/uart_rx_fifo.sv
// Small receive FIFO with flush, head always visible.
// Assumes push on full comes only with a pop; pop on empty is ignored.
`include "uart_defs.svh"
module uart_rx_fifo
  import uart_pkg::*;
#(
  parameter int DEPTH = `RX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  // Control
  input  wire logic         push_i,
  input  wire rx_entry_type push_data_i,
  input  wire logic         pop_i,
  input  wire logic         flush_i,
  // State
  output rx_entry_type      head_o,
  output logic              empty_o,
  output logic              full_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  rx_entry_type  mem_q [DEPTH];
  logic [PW-1:0] rd_ptr_q;
  logic [PW-1:0] wr_ptr_q;
  logic [PW:0]   count_q;
  logic          do_push;
  logic          do_pop;

  // Pop frees the head slot in the same cycle, so a full FIFO still takes the push
  assign do_push = push_i && ((count_q != (PW+1)'(DEPTH)) || pop_i);
  assign do_pop  = pop_i && (count_q != '0);
  assign empty_o = (count_q == '0);
  assign full_o  = (count_q == (PW+1)'(DEPTH));
  assign head_o  = mem_q[rd_ptr_q];

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk_sys_i) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= push_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || flush_i) begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (do_pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      count_q <= count_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

endmodule

// File: core/uart_data_buffer_status.sv
// Serial transceiver data port, transmit/receive buffering and status register A.
// Assumes a one-cycle I/O port access and a synchronous receive line input.
`include "uart_defs.svh"
module uart_data_buffer_status
  import uart_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_b_i,
  // I/O register port
  input  wire logic [`IO_ADDR_W-1:0] io_addr_i,
  input  wire logic                  io_rd_i,
  input  wire logic                  io_wr_i,
  input  wire logic [7:0]            io_wdata_i,
  output logic      [7:0]            io_rdata_o,
  // Configuration
  input  wire logic                  tx_enable_i,
  input  wire logic                  rx_enable_i,
  input  wire logic                  sync_mode_i,
  input  wire frame_cfg_type         frame_cfg_i,
  input  wire logic [11:0]           baud_divisor_i,
  input  wire logic [7:0]            frame_control_i,
  input  wire irq_type               irq_enable_i,
  input  wire logic                  txc_irq_ack_i,
  // Interrupt requests
  output irq_type                    irq_o,
  // Serial line
  input  wire logic                  rxd_i,
  output logic                       txd_o
);

  // Register state
  logic           u2x_q;
  logic           multiprocessor_filter_bit_q;
  logic           txc_q;
  logic           dor_q;
  logic           prev_baud_hi_q;
  logic [7:0]     rdata_q;
  irq_type        irq_q;

  // Transmit side
  logic [7:0]     tx_hold_q;
  logic           tx_hold_valid_q;
  line_state_type tx_state_q;
  logic [7:0]     tx_shift_q;
  logic [3:0]     tx_bit_q;
  logic [4:0]     tx_sub_q;
  logic           tx_par_q;
  logic           txd_q;
  logic           tx_load;
  logic           tx_done;

  // Receive side
  line_state_type rx_state_q;
  logic [7:0]     rx_shift_q;
  logic [3:0]     rx_bit_q;
  logic [4:0]     rx_sub_q;
  logic           rx_par_q;
  rx_entry_type   rx_wait_q;
  logic           rx_wait_valid_q;
  logic           rx_frame_done;
  rx_entry_type   rx_frame;
  logic           rx_start_seen;

  // Baud generator
  logic [11:0]    baud_cnt_q;
  logic           tick;
  logic [4:0]     os_len;

  // Access decode
  logic           wr_data;
  logic           wr_status;
  logic           rd_data;
  logic           rd_status;
  logic           acc_baud_hi;

  // FIFO
  rx_entry_type   fifo_head;
  logic           fifo_empty;
  logic           fifo_full;
  logic           fifo_push;
  rx_entry_type   fifo_push_data;

  logic [3:0]     char_bits;

  function automatic logic [7:0] char_mask(input logic [1:0] size);
    char_mask = 8'h1F << size;
    char_mask = ~(~char_mask << 1) | 8'h1F;
    char_mask = (8'h01 << (size + 3'd5)) - 8'h01;
    if (size == 2'd3) begin
      char_mask = 8'hFF;
    end
  endfunction

  assign char_bits   = 4'd5 + {2'b00, frame_cfg_i.char_size};
  assign wr_data     = io_wr_i && (io_addr_i == `ADDR_DATA_PORT);
  assign wr_status   = io_wr_i && (io_addr_i == `ADDR_STATUS_A);
  assign rd_data     = io_rd_i && (io_addr_i == `ADDR_DATA_PORT);
  assign rd_status   = io_rd_i && (io_addr_i == `ADDR_STATUS_A);
  assign acc_baud_hi = (io_rd_i || io_wr_i) && (io_addr_i == `ADDR_BAUD_HIGH);

  // Doubling only applies to asynchronous frames
  assign os_len = (u2x_q && !sync_mode_i) ? `OS_DOUBLE : `OS_NORMAL;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      baud_cnt_q <= 12'h000;
    end else if (baud_cnt_q == 12'h000) begin
      baud_cnt_q <= baud_divisor_i;
    end else begin
      baud_cnt_q <= baud_cnt_q - 12'h001;
    end
  end
  assign tick = (baud_cnt_q == 12'h000);

  // Status register writable bits
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      u2x_q  <= 1'(`STATUS_A_RESET >> `BIT_U2X);
      multiprocessor_filter_bit_q <= 1'(`STATUS_A_RESET >> `BIT_MULTIPROCESSOR_FILTER_BIT);
    end else if (wr_status) begin
      // Flag positions do not store (a one written at TXC clears that flag); only the two control bits store
      u2x_q  <= io_wdata_i[`BIT_U2X];
      multiprocessor_filter_bit_q <= io_wdata_i[`BIT_MULTIPROCESSOR_FILTER_BIT];
    end
  end

  // Transmit holding buffer
  assign tx_load = tx_hold_valid_q && tx_enable_i && (tx_state_q == LINE_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_hold_valid_q <= 1'b0;
      tx_hold_q       <= 8'h00;
    end else if (wr_data && !tx_hold_valid_q) begin
      // Full buffer drops the write, pending data kept
      tx_hold_q       <= io_wdata_i;
      tx_hold_valid_q <= 1'b1;
    end else if (tx_load) begin
      tx_hold_valid_q <= 1'b0;
    end
  end

  // Transmit shifter
  assign tx_done = tick && (tx_state_q == LINE_STOP) && (tx_sub_q == os_len - 5'd1)
                   && (tx_bit_q == 4'd0);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_state_q <= LINE_IDLE;
      tx_shift_q <= 8'h00;
      tx_bit_q   <= 4'd0;
      tx_sub_q   <= 5'd0;
      tx_par_q   <= 1'b0;
      txd_q      <= `TXD_IDLE;
    end else begin
      unique case (tx_state_q)
        LINE_IDLE: begin
          txd_q <= `TXD_IDLE;
          if (tx_load) begin
            tx_shift_q <= tx_hold_q & char_mask(frame_cfg_i.char_size);
            tx_par_q   <= frame_cfg_i.parity_odd;
            tx_sub_q   <= 5'd0;
            tx_state_q <= LINE_START;
            txd_q      <= 1'b0;
          end
        end
        LINE_START: begin
          if (tick && tx_sub_q == os_len - 5'd1) begin
            tx_sub_q   <= 5'd0;
            tx_bit_q   <= char_bits - 4'd1;
            txd_q      <= tx_shift_q[0];
            tx_par_q   <= tx_par_q ^ tx_shift_q[0];
            tx_shift_q <= tx_shift_q >> 1;
            tx_state_q <= LINE_DATA;
          end else if (tick) begin
            tx_sub_q <= tx_sub_q + 5'd1;
          end
        end
        LINE_DATA: begin
          if (tick && tx_sub_q == os_len - 5'd1) begin
            tx_sub_q <= 5'd0;
            if (tx_bit_q != 4'd0) begin
              tx_bit_q   <= tx_bit_q - 4'd1;
              txd_q      <= tx_shift_q[0];
              tx_par_q   <= tx_par_q ^ tx_shift_q[0];
              tx_shift_q <= tx_shift_q >> 1;
            end else if (frame_cfg_i.parity_en) begin
              txd_q      <= tx_par_q;
              tx_state_q <= LINE_PARITY;
            end else begin
              txd_q      <= 1'b1;
              tx_bit_q   <= {3'b000, frame_cfg_i.two_stop};
              tx_state_q <= LINE_STOP;
            end
          end else if (tick) begin
            tx_sub_q <= tx_sub_q + 5'd1;
          end
        end
        LINE_PARITY: begin
          if (tick && tx_sub_q == os_len - 5'd1) begin
            tx_sub_q   <= 5'd0;
            txd_q      <= 1'b1;
            tx_bit_q   <= {3'b000, frame_cfg_i.two_stop};
            tx_state_q <= LINE_STOP;
          end else if (tick) begin
            tx_sub_q <= tx_sub_q + 5'd1;
          end
        end
        LINE_STOP: begin
          if (tick && tx_sub_q == os_len - 5'd1) begin
            tx_sub_q <= 5'd0;
            if (tx_bit_q != 4'd0) begin
              tx_bit_q <= tx_bit_q - 4'd1;
            end else begin
              tx_state_q <= LINE_IDLE;
            end
          end else if (tick) begin
            tx_sub_q <= tx_sub_q + 5'd1;
          end
        end
        default: begin
          tx_state_q <= LINE_IDLE;
          txd_q      <= `TXD_IDLE;
        end
      endcase
    end
  end

  // Transmit complete: set wins over both clear sources
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      txc_q <= 1'(`STATUS_A_RESET >> `BIT_TXC);
    end else if (tx_done && !tx_hold_valid_q) begin
      txc_q <= 1'b1;
    end else if (txc_irq_ack_i || (wr_status && io_wdata_i[`BIT_TXC])) begin
      txc_q <= 1'b0;
    end
  end

  // Receiver
  assign rx_start_seen = tick && (rx_state_q == LINE_IDLE) && !rxd_i;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !rx_enable_i) begin
      rx_state_q    <= LINE_IDLE;
      rx_shift_q    <= 8'h00;
      rx_bit_q      <= 4'd0;
      rx_sub_q      <= 5'd0;
      rx_par_q      <= 1'b0;
      rx_frame_done <= 1'b0;
      rx_frame      <= '0;
    end else begin
      rx_frame_done <= 1'b0;
      unique case (rx_state_q)
        LINE_IDLE: begin
          if (rx_start_seen) begin
            rx_sub_q   <= 5'd1;
            rx_state_q <= LINE_START;
          end
        end
        LINE_START: begin
          if (tick && rx_sub_q == (os_len >> 1) - 5'd1) begin
            rx_sub_q   <= 5'd0;
            rx_shift_q <= 8'h00;
            rx_bit_q   <= char_bits;
            rx_par_q   <= frame_cfg_i.parity_odd;
            // Glitch shorter than half a bit is not a start
            rx_state_q <= rxd_i ? LINE_IDLE : LINE_DATA;
          end else if (tick) begin
            rx_sub_q <= rx_sub_q + 5'd1;
          end
        end
        LINE_DATA: begin
          if (tick && rx_sub_q == os_len - 5'd1) begin
            rx_sub_q   <= 5'd0;
            // Unused upper bits stay zero
            rx_shift_q <= rx_shift_q | ({7'h00, rxd_i} << (char_bits - rx_bit_q));
            rx_par_q   <= rx_par_q ^ rxd_i;
            rx_bit_q   <= rx_bit_q - 4'd1;
            if (rx_bit_q == 4'd1) begin
              rx_state_q <= frame_cfg_i.parity_en ? LINE_PARITY : LINE_STOP;
            end
          end else if (tick) begin
            rx_sub_q <= rx_sub_q + 5'd1;
          end
        end
        LINE_PARITY: begin
          if (tick && rx_sub_q == os_len - 5'd1) begin
            rx_sub_q   <= 5'd0;
            rx_par_q   <= rx_par_q ^ rxd_i;
            rx_state_q <= LINE_STOP;
          end else if (tick) begin
            rx_sub_q <= rx_sub_q + 5'd1;
          end
        end
        LINE_STOP: begin
          // Only the first stop bit is checked
          if (tick && rx_sub_q == os_len - 5'd1) begin
            rx_sub_q            <= 5'd0;
            rx_frame.data       <= rx_shift_q;
            rx_frame.frame_err  <= !rxd_i;
            rx_frame.parity_err <= frame_cfg_i.parity_en && rx_par_q;
            rx_frame_done       <= 1'b1;
            rx_state_q          <= LINE_IDLE;
          end else if (tick) begin
            rx_sub_q <= rx_sub_q + 5'd1;
          end
        end
        default: begin
          rx_state_q <= LINE_IDLE;
        end
      endcase
    end
  end

  // Waiting character in the shift stage when the FIFO is full
  assign fifo_push      = rx_enable_i && (rx_wait_valid_q || rx_frame_done) && (!fifo_full || rd_data);
  assign fifo_push_data = rx_wait_valid_q ? rx_wait_q : rx_frame;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !rx_enable_i) begin
      rx_wait_valid_q <= 1'b0;
      rx_wait_q       <= '0;
    end else if (rx_frame_done && (rx_wait_valid_q || !fifo_push)) begin
      // A newer frame replaces a waiting one after an overrun
      rx_wait_q       <= rx_frame;
      rx_wait_valid_q <= 1'b1;
    end else if (fifo_push && rx_wait_valid_q) begin
      rx_wait_valid_q <= 1'b0;
    end
  end

  uart_rx_fifo #(
    .DEPTH (`RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .push_i      (fifo_push),
    .push_data_i (fifo_push_data),
    .pop_i       (rd_data),
    .flush_i     (!rx_enable_i),
    .head_o      (fifo_head),
    .empty_o     (fifo_empty),
    .full_o      (fifo_full)
  );

  // Overrun: set wins over the clearing read
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !rx_enable_i) begin
      dor_q <= 1'(`STATUS_A_RESET >> `BIT_DOR);
    end else if (rx_start_seen && fifo_full && rx_wait_valid_q) begin
      dor_q <= 1'b1;
    end else if (rd_data) begin
      dor_q <= 1'b0;
    end
  end

  // Read data path and shared baud-high location
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      prev_baud_hi_q <= 1'b0;
    end else begin
      prev_baud_hi_q <= acc_baud_hi;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else if (rd_data) begin
      rdata_q <= fifo_empty ? 8'h00 : fifo_head.data;
    end else if (rd_status) begin
      rdata_q <= 8'h00;
      rdata_q[`BIT_RXC]  <= !fifo_empty;
      rdata_q[`BIT_TXC]  <= txc_q;
      rdata_q[`BIT_BUFFER_EMPTY_FLAG] <= !tx_hold_valid_q;
      rdata_q[`BIT_FE]   <= !fifo_empty && fifo_head.frame_err;
      rdata_q[`BIT_DOR]  <= dor_q;
      rdata_q[`BIT_PE]   <= !fifo_empty && fifo_head.parity_err;
      rdata_q[`BIT_U2X]  <= u2x_q;
      rdata_q[`BIT_MULTIPROCESSOR_FILTER_BIT] <= multiprocessor_filter_bit_q;
    end else if (io_rd_i && io_addr_i == `ADDR_BAUD_HIGH) begin
      // Back-to-back access turns the location into frame control
      rdata_q <= prev_baud_hi_q ? frame_control_i : {4'h0, baud_divisor_i[11:8]};
    end
  end

  // Interrupt requests
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      irq_q <= '0;
    end else begin
      irq_q.receive_complete_flag  <= irq_enable_i.receive_complete_flag && !fifo_empty;
      irq_q.transmit_complete_flag  <= irq_enable_i.transmit_complete_flag && txc_q;
      irq_q.buffer_empty_flag <= irq_enable_i.buffer_empty_flag && !tx_hold_valid_q;
    end
  end

  assign io_rdata_o = rdata_q;
  assign irq_o      = irq_q;
  assign txd_o      = txd_q;

endmodule

// File: verif/uart_data_buffer_status_checker.sv
// Port-level checks for the serial data buffer and status register A.
// Assumes a bind onto uart_data_buffer_status; one clock domain.
`include "uart_defs.svh"
module uart_data_buffer_status_checker
  import uart_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  rst_b_i,
  // Register port
  input wire logic [`IO_ADDR_W-1:0] io_addr_i,
  input wire logic                  io_rd_i,
  input wire logic [7:0]            io_rdata_o,
  // Control and requests
  input wire logic                  rx_enable_i,
  input wire irq_type               irq_enable_i,
  input wire logic                  txc_irq_ack_i,
  input wire irq_type               irq_o,
  // Serial out
  input wire logic                  txd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  logic mapped;
  assign mapped = io_addr_i inside {`ADDR_DATA_PORT, `ADDR_STATUS_A, `ADDR_BAUD_HIGH};

  AST_RD_HOLD: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data changed without a read");
  AST_RD_UNMAPPED: assert property (io_rd_i && !mapped |=> $stable(io_rdata_o))
    else $error("unmapped read changed read data");
  AST_RXC_MASK: assert property (!irq_enable_i.receive_complete_flag |=> !irq_o.receive_complete_flag)
    else $error("receive request while masked");
  AST_BUFFER_EMPTY_FLAG_MASK: assert property (!irq_enable_i.buffer_empty_flag |=> !irq_o.buffer_empty_flag)
    else $error("empty request while masked");
  AST_TXC_ACK: assert property (txc_irq_ack_i |-> ##2 !irq_o.transmit_complete_flag)
    else $error("transmit request survived service");
  AST_BUFFER_EMPTY_FLAG_RESET: assert property ($rose(rst_b_i) && irq_enable_i.buffer_empty_flag |=> irq_o.buffer_empty_flag)
    else $error("buffer empty request missing after reset");
  // Eight clocks is the shortest legal bit, at doubled speed and divisor zero
  AST_BIT_MIN: assert property ($fell(txd_o) |-> !txd_o [*8])
    else $error("low bit on serial out too short");
  AST_RX_FLUSH: assert property (!rx_enable_i ##1 !rx_enable_i |=> !irq_o.receive_complete_flag)
    else $error("receive request with receiver off");

  cover property ($fell(txd_o));
  cover property (irq_o.receive_complete_flag);
  cover property (io_rd_i && io_addr_i == `ADDR_BAUD_HIGH ##1 io_rd_i);
endmodule

// File: verif/serial_peer_model.sv
// Remote serial peer: sends frames on the receive line, decodes the transmit line.
// Assumes one bit lasts bit_clks_i system clocks and parity is even.
module serial_peer_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Serial lines
  input  wire logic       txd_i,
  output logic            rxd_o,
  // Frame setup
  input  wire logic [4:0] bit_clks_i,
  input  wire logic [3:0] nbits_i,
  input  wire logic       par_en_i,
  // Decoded transmit data
  output logic [7:0]      rx_byte_o,
  output logic            rx_stb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  initial begin
    rxd_o = 1'b1;
    rx_stb_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  task automatic bit_out(input logic v);
    rxd_o = v;
    repeat (bit_clks_i) @(negedge clk_sys_i);
  endtask
  task automatic send(input logic [7:0] v, input logic bad_par, input logic stop_v);
    logic [7:0] m;
    m = v & ((8'h01 << nbits_i) - 8'h01);
    @(negedge clk_sys_i);
    bit_out(1'b0);
    for (int i = 0; i < nbits_i; i++) bit_out(m[i]);
    if (par_en_i) bit_out(^m ^ bad_par);
    bit_out(stop_v);
    // Line returns high; the low tail of a zero stop may still frame a spurious character
    if (!stop_v) bit_out(1'b1);
  endtask
  // Sampled on the falling edge, away from the registered output change
  always begin
    @(negedge txd_i);
    sh = 8'h00;
    repeat (bit_clks_i / 2) @(negedge clk_sys_i);
    for (int i = 0; i < nbits_i; i++) begin
      repeat (bit_clks_i) @(negedge clk_sys_i);
      sh[i] = txd_i;
    end
    if (par_en_i) repeat (bit_clks_i) @(negedge clk_sys_i);
    repeat (bit_clks_i) @(negedge clk_sys_i);
    if (txd_i) begin
      rx_byte_o = sh;
      rx_stb_o = 1'b1;
      @(negedge clk_sys_i);
      rx_stb_o = 1'b0;
    end
  end
endmodule

// File: verif/uart_data_buffer_status_tb.sv
// Self-checking bench for the serial data buffer and status register A.
// Assumes the design, the checker and the serial peer model are compiled first.
`include "uart_defs.svh"
module uart_data_buffer_status_tb import uart_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] DP = `ADDR_DATA_PORT;
  localparam logic [5:0] ST = `ADDR_STATUS_A;
  localparam logic [5:0] BH = `ADDR_BAUD_HIGH;
  logic          clk_sys_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic [5:0]    io_addr_i = 6'h00;
  logic          io_rd_i = 1'b0;
  logic          io_wr_i = 1'b0;
  logic [7:0]    io_wdata_i = 8'h00;
  logic [7:0]    io_rdata_o;
  logic          tx_enable_i = 1'b1;
  logic          rx_enable_i = 1'b0;
  logic          sync_mode_i = 1'b0;
  frame_cfg_type frame_cfg_i = 5'h18;
  logic [11:0]   baud_divisor_i = 12'h000;
  logic [7:0]    frame_control_i = 8'h00;
  irq_type       irq_enable_i = 3'h0;
  logic          txc_irq_ack_i = 1'b0;
  irq_type       irq_o;
  logic          rxd_i;
  logic          txd_o;
  logic [4:0]    bclk = 5'h10;
  logic [3:0]    nbits = 4'h8;
  logic          rd_seen = 1'b0;
  logic [15:0]   e;
  logic [15:0]   exp_q[$];
  logic [7:0]    tx_q[$];
  logic [7:0]    peer_byte;
  logic          peer_stb;
  logic [7:0]    d[4];
  int            n_errors = 0;
  int            tests_run = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  uart_data_buffer_status uart_data_buffer_status_i (.clk_sys_i, .rst_b_i, .io_addr_i,
    .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o, .tx_enable_i, .rx_enable_i, .sync_mode_i,
    .frame_cfg_i, .baud_divisor_i, .frame_control_i, .irq_enable_i, .txc_irq_ack_i, .irq_o,
    .rxd_i, .txd_o);
  serial_peer_model serial_peer_model_i (.clk_sys_i, .txd_i(txd_o), .rxd_o(rxd_i),
    .bit_clks_i(bclk), .nbits_i(nbits), .par_en_i(frame_cfg_i.parity_en),
    .rx_byte_o(peer_byte), .rx_stb_o(peer_stb));

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] s);
    tests_run++;
    if (s !== ex) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, s);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Strobe held n edges; each edge is one access
  task automatic acc(input logic r, w, input logic [5:0] a, input logic [7:0] v, input int n);
    @(negedge clk_sys_i);
    io_rd_i = r;
    io_wr_i = w;
    io_addr_i = a;
    io_wdata_i = v;
    repeat (n) @(negedge clk_sys_i);
    io_rd_i = 1'b0;
    io_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] ex);
    exp_q.push_back({m, ex & m});
    acc(1'b1, 1'b0, a, 8'h00, 1);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    acc(1'b0, 1'b1, a, v, 1);
  endtask
  task automatic wait_irq(input int b);
    int k;
    k = 0;
    while (irq_o[b] !== 1'b1 && k < 4000) begin
      @(negedge clk_sys_i);
      k++;
    end
    if (k == 4000) chk("irq_wait", 8'h01, 8'h00);
  endtask

  always @(posedge clk_sys_i) rd_seen <= io_rd_i;
  always @(negedge clk_sys_i) begin
    if (rd_seen) begin
      e = exp_q.size() ? exp_q.pop_front() : 16'hffxx;
      chk("rdata", e[7:0], io_rdata_o & e[15:8]);
    end
  end
  always @(posedge peer_stb) chk("txd_byte", tx_q.size() ? tx_q.pop_front() : 8'hxx, peer_byte);

  initial begin
    #400_000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h3a44_4118));
    frame_control_i = 8'($urandom_range(1, 255));
    repeat (12) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    rd(ST, 8'hff, 8'h20);
    rd(6'h3f, 8'hff, 8'h20);
    exp_q.push_back({8'hff, 8'h00});
    exp_q.push_back({8'hff, frame_control_i});
    acc(1'b1, 1'b0, BH, 8'h00, 2);
    rd(BH, 8'hff, 8'h00);
    irq_enable_i = 3'h7;
    for (int i = 0; i < 2; i++) d[i] = 8'($urandom);
    tx_q = {d[0], d[1]};
    wr(DP, d[0]);
    wr(DP, d[1]);
    wr(DP, ~d[1]);
    wait_irq(1);
    rd(ST, 8'he0, 8'h60);
    wr(ST, 8'ha0);
    rd(ST, 8'he0, 8'h60);
    wr(ST, 8'h40);
    rd(ST, 8'h40, 8'h00);
    frame_cfg_i = 5'h00;
    nbits = 4'h5;
    wr(ST, 8'h02);
    bclk = 5'h08;
    d[2] = 8'($urandom) | 8'he0;
    tx_q.push_back(d[2] & 8'h1f);
    tx_enable_i = 1'b0;
    wr(DP, d[2]);
    rd(ST, 8'h60, 8'h00);
    tx_enable_i = 1'b1;
    wait_irq(1);
    txc_irq_ack_i = 1'b1;
    @(negedge clk_sys_i);
    txc_irq_ack_i = 1'b0;
    rd(ST, 8'h42, 8'h02);
    rx_enable_i = 1'b1;
    d[3] = 8'($urandom);
    serial_peer_model_i.send(d[3], 1'b0, 1'b1);
    rd(ST, 8'h80, 8'h80);
    chk("irq", 8'h05, {5'h00, irq_o});
    rd(DP, 8'hff, d[3] & 8'h1f);
    rd(ST, 8'h80, 8'h00);
    wr(ST, 8'h00);
    bclk = 5'h10;
    nbits = 4'h8;
    frame_cfg_i = 5'h1c;
    for (int i = 0; i < 2; i++) d[i] = 8'($urandom);
    serial_peer_model_i.send(d[0], 1'b1, 1'b1);
    serial_peer_model_i.send(d[1], 1'b0, 1'b0);
    rd(ST, 8'h9c, 8'h84);
    rd(DP, 8'hff, d[0]);
    rd(ST, 8'h9c, 8'h90);
    rd(DP, 8'hff, d[1]);
    rx_enable_i = 1'b0;
    rd(ST, 8'h80, 8'h00);
    rx_enable_i = 1'b1;
    // Odd parity: the peer's even parity bit inverted
    frame_cfg_i = 5'h1e;
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($urandom);
      serial_peer_model_i.send(d[i], 1'b1, 1'b1);
    end
    rd(ST, 8'h8c, 8'h88);
    rd(DP, 8'hff, d[0]);
    rd(DP, 8'hff, d[1]);
    rd(DP, 8'hff, d[3]);
    repeat (4) @(negedge clk_sys_i);
    chk("tx_left", 8'h00, 8'(tx_q.size()));
    rst_b_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    rd(ST, 8'hff, 8'h20);
    repeat (4) @(negedge clk_sys_i);
    report_and_stop();
  end
endmodule

bind uart_data_buffer_status uart_data_buffer_status_checker uart_data_buffer_status_checker_i (
  .clk_sys_i, .rst_b_i, .io_addr_i, .io_rd_i, .io_rdata_o, .rx_enable_i, .irq_enable_i,
  .txc_irq_ack_i, .irq_o, .txd_o);
